// >>> rtl/scu_params.svh
// Constants for the string compare unit: encodings, element sizes, cc codes.
// Assumes inclusion by the core and the testbench only.
`ifndef SCU_PARAMS_SVH
`define SCU_PARAMS_SVH
`define SCU_PFX_BW 7'b1011_101
`define SCU_PFX_LONG 8'b1011_1001
`define SCU_OP_DEC_REP 4'b1110
`define SCU_OP_DEC 4'b1010
`define SCU_OP_INC 4'b0010
`define SCU_W1_TOP 4'h0
`define SCU_STEP_BYTE 32'h0000_0001
`define SCU_STEP_WORD 32'h0000_0002
`define SCU_STEP_LONG 32'h0000_0004
`define SCU_PTR_COMPACT_MASK 32'h0000_FFFF
`define SCU_CNT_ONE 16'h0001
`define SCU_CNT_ZERO 16'h0000
`define SCU_CC_F 4'h0
`define SCU_CC_LT 4'h1
`define SCU_CC_LE 4'h2
`define SCU_CC_ULE 4'h3
`define SCU_CC_OV 4'h4
`define SCU_CC_MI 4'h5
`define SCU_CC_EQ 4'h6
`define SCU_CC_ULT 4'h7
`define SCU_CC_T 4'h8
`define SCU_CC_GE 4'h9
`define SCU_CC_GT 4'hA
`define SCU_CC_UGT 4'hB
`define SCU_CC_NOV 4'hC
`define SCU_CC_PL 4'hD
`define SCU_CC_NE 4'hE
`define SCU_CC_UGE 4'hF
`endif

// >>> rtl/scu_pkg.sv
// Types of the string compare unit.
// Assumes scu_params.svh is reachable on the include path.
`default_nettype none
package scu_pkg;
    // Element size of one compare step
    typedef enum logic [1:0] {SCU_SZ_BYTE, SCU_SZ_WORD, SCU_SZ_LONG} scu_size_type;
    // Flag word: the four flags written, the rest kept
    typedef struct packed {
        logic c;
        logic z;
        logic s;
        logic v;
        logic [3:0] other;
    } scu_flags_type;
    // Memory read request toward the access path
    typedef struct packed {
        logic req;
        logic [31:0] addr;
        scu_size_type size;
    } scu_mem_req_type;
    // Architectural results handed back to the register file
    typedef struct packed {
        logic [31:0] dst_ptr;
        logic [31:0] source_pointer;
        logic [15:0] count;
        scu_flags_type flags;
    } scu_arch_type;
endpackage : scu_pkg
`default_nettype wire

// >>> rtl/scu_core.sv
// String compare execution unit: decodes the compare-string forms, reads
// elements, compares, steps pointers and counter, writes flags.
// Assumes a memory path that answers each held request with a one-cycle ack
// and a decoder that pulses start with stable operands.
//
// Behaviour
// - Repeat decrement form steps both pointers down by 1, 2 or 4.
// - Repeat form loops until test_condition holds or counter reaches zero.
// - Compare is destination minus source; only flags change, never memory.
// - Z set when last comparison satisfies test_condition, cleared otherwise.
// - C cleared on carry out of msb, set on borrow.
// - S set when last comparison result is negative.
// - V set when decremented counter is zero.
// - Repeat form may stop between steps with pointers, counter, flags consistent.
// - Decode repeat byte/word: 1011101 W src 1110, then 0000 r dst cc.
// - Decode long single decrement: 10111001 src 1010, then 0000 r dst cc.
// - Incrementing single step: one compare, pointers up by size, counter down.
// - Compact mode uses 16-bit pointers, other modes 32-bit.
// - Decrementing single step: one compare, pointers down, counter once.
`default_nettype none
`include "scu_params.svh"
module scu_core
    import scu_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic [15:0] instr_w0,
    input wire logic [15:0] instr_w1,
    input wire logic compact_mode,
    input wire logic irq_pending,
    input wire scu_arch_type arch_in,
    output scu_mem_req_type mem_out,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    output logic busy,
    output logic done,
    output logic bad_op,
    output logic suspended,
    output scu_arch_type arch_out
);

    typedef enum logic [2:0] {ST_IDLE, ST_RD_DST, ST_RD_SRC, ST_STEP} scu_state_type;

    typedef struct packed {
        scu_state_type st;
        scu_size_type size;
        logic inc;
        logic rep;
        logic compact;
        logic [3:0] cond;
        logic [31:0] dst_data;
        scu_mem_req_type mem;
        logic busy;
        logic done;
        logic bad_op;
        logic suspended;
        scu_arch_type arch;
    } scu_regs_type;

    scu_regs_type r;
    scu_regs_type next_r;

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Size-dependent pointer step
    function automatic logic [31:0] step_of(input scu_size_type sz);
        case (sz)
            SCU_SZ_BYTE: step_of = `SCU_STEP_BYTE;
            SCU_SZ_WORD: step_of = `SCU_STEP_WORD;
            default: step_of = `SCU_STEP_LONG;
        endcase
    endfunction : step_of

    // Standard condition table on fresh compare flags
    function automatic logic cond_met(input logic [3:0] cc, input logic c, input logic z,
                                      input logic s, input logic v);
        case (cc)
            `SCU_CC_F: cond_met = 1'b0;
            `SCU_CC_LT: cond_met = s ^ v;
            `SCU_CC_LE: cond_met = z | (s ^ v);
            `SCU_CC_ULE: cond_met = c | z;
            `SCU_CC_OV: cond_met = v;
            `SCU_CC_MI: cond_met = s;
            `SCU_CC_EQ: cond_met = z;
            `SCU_CC_ULT: cond_met = c;
            `SCU_CC_T: cond_met = 1'b1;
            `SCU_CC_GE: cond_met = ~(s ^ v);
            `SCU_CC_GT: cond_met = ~(z | (s ^ v));
            `SCU_CC_UGT: cond_met = ~(c | z);
            `SCU_CC_NOV: cond_met = ~v;
            `SCU_CC_PL: cond_met = ~s;
            `SCU_CC_NE: cond_met = ~z;
            default: cond_met = ~c;
        endcase
    endfunction : cond_met

    // Left-align an element so its msb sits at bit 31
    function automatic logic [31:0] align(input logic [31:0] d, input scu_size_type sz);
        case (sz)
            SCU_SZ_BYTE: align = {d[7:0], 24'h00_0000};
            SCU_SZ_WORD: align = {d[15:0], 16'h0000};
            default: align = d;
        endcase
    endfunction : align

    // Instruction word field checks
    logic w1_ok;
    logic bw_form;
    logic long_form;
    assign w1_ok = (instr_w1[15:12] == `SCU_W1_TOP) && (instr_w1[7:4] != 4'h0);
    assign bw_form = (instr_w0[15:9] == `SCU_PFX_BW) && (instr_w0[7:4] != 4'h0);
    assign long_form = (instr_w0[15:8] == `SCU_PFX_LONG) && (instr_w0[7:4] != 4'h0);

    ////////////////////////////////////////////////////////////////////////////
    // Compare datapath: operands aligned so one 33-bit subtract serves all sizes
    logic [31:0] op_a;
    logic [31:0] op_b;
    logic [32:0] diff;
    logic f_c;
    logic f_z;
    logic f_s;
    logic f_v;
    logic [15:0] cnt_dec;
    logic [31:0] dst_nx;
    logic [31:0] src_nx;
    logic hit;

    assign op_a = align(r.dst_data, r.size);
    assign op_b = align(mem_rdata, r.size);
    assign diff = {1'b0, op_a} - {1'b0, op_b};
    assign f_c = diff[32];
    assign f_z = (diff[31:0] == 32'h0000_0000);
    assign f_s = diff[31];
    assign f_v = (op_a[31] ^ op_b[31]) & (op_a[31] ^ diff[31]);
    assign hit = cond_met(r.cond, f_c, f_z, f_s, f_v);
    assign cnt_dec = r.arch.count - `SCU_CNT_ONE;

    // Pointer steps; compact mode wraps within 16 bits
    always_comb begin
        logic [31:0] st;
        st = step_of(r.size);
        dst_nx = r.inc ? r.arch.dst_ptr + st : r.arch.dst_ptr - st;
        src_nx = r.inc ? r.arch.source_pointer + st : r.arch.source_pointer - st;
        if (r.compact) begin
            dst_nx = dst_nx & `SCU_PTR_COMPACT_MASK;
            src_nx = src_nx & `SCU_PTR_COMPACT_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        case (r.st)
            ST_IDLE: begin
                if (start) begin
                    next_r.bad_op = 1'b0;
                    next_r.suspended = 1'b0;
                    next_r.arch = arch_in;
                    next_r.compact = compact_mode;
                    next_r.cond = instr_w1[3:0];
                    next_r.size = instr_w0[8] ? SCU_SZ_WORD : SCU_SZ_BYTE;
                    next_r.inc = (instr_w0[3:0] == `SCU_OP_INC);
                    next_r.rep = (instr_w0[3:0] == `SCU_OP_DEC_REP);
                    if (long_form) begin
                        next_r.size = SCU_SZ_LONG;
                    end
                    if (compact_mode) begin
                        next_r.arch.dst_ptr = arch_in.dst_ptr & `SCU_PTR_COMPACT_MASK;
                        next_r.arch.source_pointer = arch_in.source_pointer
                                                     & `SCU_PTR_COMPACT_MASK;
                    end
                    // Only the three decoded opcodes run; anything else is refused
                    if (w1_ok && (bw_form || long_form) &&
                        (instr_w0[3:0] == `SCU_OP_DEC_REP || instr_w0[3:0] == `SCU_OP_DEC ||
                         instr_w0[3:0] == `SCU_OP_INC)) begin
                        next_r.st = ST_RD_DST;
                        next_r.busy = 1'b1;
                        next_r.mem.req = 1'b1;
                        next_r.mem.addr = next_r.arch.dst_ptr;
                        next_r.mem.size = next_r.size;
                    end else begin
                        next_r.bad_op = 1'b1;
                        next_r.done = 1'b1;
                    end
                end
            end
            ST_RD_DST: begin
                if (mem_ack) begin
                    next_r.dst_data = mem_rdata;
                    next_r.mem.addr = r.arch.source_pointer;
                    next_r.st = ST_RD_SRC;
                end
            end
            ST_RD_SRC: begin
                if (mem_ack) begin
                    // One basic step: flags, pointers, counter all update together
                    next_r.mem.req = 1'b0;
                    next_r.arch.flags.c = f_c;
                    next_r.arch.flags.z = hit;
                    next_r.arch.flags.s = f_s;
                    next_r.arch.flags.v = (cnt_dec == `SCU_CNT_ZERO);
                    next_r.arch.dst_ptr = dst_nx;
                    next_r.arch.source_pointer = src_nx;
                    next_r.arch.count = cnt_dec;
                    next_r.st = ST_STEP;
                end
            end
            ST_STEP: begin
                // Stop after a single form, on hit or exhausted count, else yield to a pending interrupt
                if (!r.rep || r.arch.flags.z || r.arch.flags.v) begin
                    next_r.st = ST_IDLE;
                    next_r.busy = 1'b0;
                    next_r.done = 1'b1;
                end else if (irq_pending) begin
                    next_r.st = ST_IDLE;
                    next_r.busy = 1'b0;
                    next_r.done = 1'b1;
                    next_r.suspended = 1'b1;
                end else begin
                    next_r.st = ST_RD_DST;
                    next_r.mem.req = 1'b1;
                    next_r.mem.addr = r.arch.dst_ptr;
                end
            end
            default: next_r.st = ST_IDLE;
        endcase
    end

    // State register; other flag bits ride through untouched
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign mem_out = r.mem;
    assign busy = r.busy;
    assign done = r.done;
    assign bad_op = r.bad_op;
    assign suspended = r.suspended;
    assign arch_out = r.arch;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_step_end;
        r.st == ST_RD_SRC && mem_ack;
    endsequence

    a_dec_step_size: assert property (s_step_end ##0 (!r.inc && r.size == SCU_SZ_LONG
        && !r.compact) |=> r.arch.dst_ptr == $past(r.arch.dst_ptr) - 32'h0000_0004)
        else $error("long decrement step wrong");
    a_inc_step_size: assert property (s_step_end ##0 (r.inc && r.size == SCU_SZ_WORD
        && !r.compact) |=> r.arch.source_pointer == $past(r.arch.source_pointer) + 32'h0000_0002)
        else $error("word increment step wrong");
    a_rep_stop: assert property (r.st == ST_STEP && r.rep
        && (r.arch.flags.z || r.arch.flags.v) |=> done && !busy ##1 !done)
        else $error("repeat did not stop");
    a_match_flag: assert property (s_step_end |=> arch_out.flags.z == $past(hit))
        else $error("match flag wrong");
    a_borrow_flag: assert property (s_step_end
        |=> arch_out.flags.c == $past(op_a < op_b)) else $error("borrow flag wrong");
    a_count_done: assert property (s_step_end |=>
        arch_out.count == $past(r.arch.count) - 16'h0001
        && arch_out.flags.v == (arch_out.count == 16'h0000)) else $error("counter flag wrong");
    a_irq_yield: assert property (r.st == ST_STEP && r.rep && !r.arch.flags.z
        && !r.arch.flags.v && irq_pending |=> done && suspended)
        else $error("repeat ignored interrupt");
    a_compact_ptr: assert property (busy && r.compact
        |-> arch_out.dst_ptr[31:16] == 16'h0000 && mem_out.addr[31:16] == 16'h0000)
        else $error("compact pointer overflow");
    a_single_once: assert property (r.st == ST_STEP && !r.rep |=> done ##1 !busy)
        else $error("single step repeated");
    a_other_flags: assert property (busy && $past(busy)
        |-> arch_out.flags.other == $past(arch_out.flags.other))
        else $error("unrelated flags changed");

endmodule : scu_core
`default_nettype wire

// >>> sim/test_string_compare_unit.sv
// Self-checking bench of the string compare unit; it plays decoder and memory.
// Assumes the rtl package and scu_params.svh on the include path.
`default_nettype none
`include "scu_params.svh"
module test_string_compare_unit import scu_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic start = 1'b0;
    logic [15:0] instr_w0 = 16'h0000;
    logic [15:0] instr_w1 = 16'h0000;
    logic compact_mode = 1'b0;
    logic irq_pending = 1'b0;
    scu_arch_type arch_in = '0;
    scu_mem_req_type mem_out;
    logic mem_ack = 1'b0;
    logic [31:0] mem_rdata = 32'h0000_0000;
    logic busy, done, bad_op, suspended;
    scu_arch_type arch_out;
    logic [31:0] mem [logic [31:0]];
    int lat = 0;
    scu_size_type exp_sz = SCU_SZ_BYTE;
    int wcnt = 0;
    int n_errors = 0;
    int n_compared = 0;
    ////////////////////////////////////////////////////////////////////////
    scu_core DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .start(start),
        .instr_w0(instr_w0), .instr_w1(instr_w1), .compact_mode(compact_mode),
        .irq_pending(irq_pending), .arch_in(arch_in), .mem_out(mem_out),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy), .done(done),
        .bad_op(bad_op), .suspended(suspended), .arch_out(arch_out));
    // 100 ns clock
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    // Memory path: ack after lat waits; idle data toggles so no stale hold
    always @(posedge ref_clk) begin
        wcnt <= (mem_out.req && !mem_ack) ? wcnt + 1 : 0;
        mem_ack <= mem_out.req && !mem_ack && wcnt >= lat;
        if (mem_out.req && !mem_ack && wcnt >= lat) begin
            chk("mem size", {30'h0000_0000, exp_sz}, {30'h0000_0000, mem_out.size});
            mem_rdata <= mem.exists(mem_out.addr) ? mem[mem_out.addr] : ~mem_out.addr;
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic chk_arch(input logic [31:0] d, input logic [31:0] s,
                            input logic [15:0] c, input logic [7:0] f);
        chk("dst_ptr", d, arch_out.dst_ptr);
        chk("source_pointer", s, arch_out.source_pointer);
        chk("count", {16'h0000, c}, {16'h0000, arch_out.count});
        chk("flags", {24'h00_0000, f}, {24'h00_0000, arch_out.flags});
    endtask : chk_arch
    function automatic logic [15:0] enc(input int sz, input logic [3:0] op);
        return sz == 2 ? {`SCU_PFX_LONG, 4'h1, op} : {`SCU_PFX_BW, sz[0], 4'h1, op};
    endfunction : enc
    // Flags {c, z, s} of dst minus src at the element width, z from the cc table
    function automatic logic [2:0] cmpf(input logic [31:0] d, input logic [31:0] s,
                                       input int sz, input logic [3:0] cc);
        logic [31:0] m, h, r;
        logic b, n, z, v, t;
        m = sz == 2 ? 32'hFFFF_FFFF : (sz == 1 ? 32'h0000_FFFF : 32'h0000_00FF);
        h = m & ~(m >> 1);
        r = (d - s) & m;
        b = (d & m) < (s & m);
        n = |(r & h);
        z = r == 32'h0000_0000;
        v = (|((d ^ s) & h)) && (|((r ^ d) & h));
        case (cc[2:0])
            3'h0: t = 1'b0;
            3'h1: t = n ^ v;
            3'h2: t = z | (n ^ v);
            3'h3: t = b | z;
            3'h4: t = v;
            3'h5: t = n;
            3'h6: t = z;
            default: t = b;
        endcase
        return {b, cc[3] ^ t, n};
    endfunction : cmpf
    // One instruction: start pulse, then a bounded wait for done
    task automatic run(input logic [15:0] w0, input logic [15:0] w1, input logic cm,
                       input logic irq, input scu_arch_type a, input logic bad);
        // Element size every memory read of this instruction must carry
        exp_sz = (w0[15:8] == `SCU_PFX_LONG) ? SCU_SZ_LONG
                 : (w0[8] ? SCU_SZ_WORD : SCU_SZ_BYTE);
        @(posedge ref_clk);
        instr_w0 <= w0;
        instr_w1 <= w1;
        compact_mode <= cm;
        irq_pending <= irq;
        arch_in <= a;
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        // A refused start pulses done right after this edge: look before the next one
        #1;
        for (int k = 0; k < 400 && done !== 1'b1; k++) begin
            @(posedge ref_clk);
            #1;
        end
        chk("done", 32'h0000_0001, {31'h0000_0000, done});
        chk("bad_op", {31'h0000_0000, bad}, {31'h0000_0000, bad_op});
    endtask : run
    ////////////////////////////////////////////////////////////////////////
    task automatic t_single_dec;
        mem[32'h0000_2000] = 32'h0000_00FF;
        mem[32'h0000_3000] = 32'h0000_0000;
        run(enc(0, `SCU_OP_DEC), {12'h043, `SCU_CC_UGE}, 1'b0, 1'b0,
            {32'h0000_2000, 32'h0000_3000, 16'h0001, 8'hFA}, 1'b0);
        chk_arch(32'h0000_1FFF, 32'h0000_2FFF, 16'h0000, 8'h7A);
        // Compact mode, long element: pointers masked to 16 bits, then wrap
        mem[32'h0000_0002] = 32'h0000_0003;
        mem[32'h0000_0001] = 32'h0000_0005;
        run(enc(2, `SCU_OP_DEC), {12'h032, `SCU_CC_ULT}, 1'b1, 1'b0,
            {32'h0001_0002, 32'h0000_0001, 16'h0002, 8'h0A}, 1'b0);
        chk_arch(32'h0000_FFFE, 32'h0000_FFFD, 16'h0001, 8'hEA);
        $display("test single_dec done");
    endtask : t_single_dec
    // Every condition code once, sizes rotating, incrementing form
    task automatic t_cc_all;
        logic [31:0] d, s, st;
        int sz;
        for (int cc = 0; cc < 16; cc++) begin
            sz = cc % 3;
            st = 32'h0000_0001 << sz;
            d = {8{cc[3:0]}};
            s = 32'h7777_7777;
            mem[32'h0000_0100] = d;
            mem[32'h0000_0200] = s;
            run(enc(sz, `SCU_OP_INC), {12'h032, cc[3:0]}, 1'b0, 1'b0,
                {32'h0000_0100, 32'h0000_0200, 16'h0005, 8'h5A}, 1'b0);
            chk_arch(32'h0000_0100 + st, 32'h0000_0200 + st, 16'h0004,
                     {cmpf(d, s, sz, cc[3:0]), 1'b0, 4'hA});
        end
        $display("test cc_all done");
    endtask : t_cc_all
    // Repeat runs to zero count on a slow memory, then stops early on a hit
    task automatic t_repeat;
        for (int i = 0; i < 4; i++) begin
            mem[32'h0000_1000 + 2 * i] = 2 * i;
            mem[32'h0000_2000 + 2 * i] = (i == 1 || i == 2) ? 1 : 0;
        end
        lat = 2;
        run(enc(1, `SCU_OP_DEC_REP), {12'h032, `SCU_CC_EQ}, 1'b1, 1'b0,
            {32'h0000_1006, 32'h0000_2006, 16'h0004, 8'h0A}, 1'b0);
        chk_arch(32'h0000_0FFE, 32'h0000_1FFE, 16'h0000, 8'h5A);
        lat = 0;
        mem[32'h0000_1000] = 32'h0000_0005;
        mem[32'h0000_2000] = 32'h0000_0009;
        mem[32'h0000_0FFC] = 32'h0000_0007;
        mem[32'h0000_1FFC] = 32'h0000_0007;
        run(enc(2, `SCU_OP_DEC_REP), {12'h032, `SCU_CC_EQ}, 1'b0, 1'b0,
            {32'h0000_1000, 32'h0000_2000, 16'h0008, 8'hFA}, 1'b0);
        chk_arch(32'h0000_0FF8, 32'h0000_1FF8, 16'h0006, 8'h4A);
        $display("test repeat done");
    endtask : t_repeat
    // Interrupt stops the repeat after one step; resuming finishes it
    task automatic t_irq;
        mem[32'h0000_0010] = 32'h0000_0001;
        mem[32'h0000_0020] = 32'h0000_0002;
        mem[32'h0000_000F] = 32'h0000_0004;
        mem[32'h0000_001F] = 32'h0000_0004;
        run(enc(0, `SCU_OP_DEC_REP), {12'h032, `SCU_CC_EQ}, 1'b0, 1'b1,
            {32'h0000_0010, 32'h0000_0020, 16'h0003, 8'h0A}, 1'b0);
        chk("suspended", 32'h0000_0001, {31'h0000_0000, suspended});
        chk_arch(32'h0000_000F, 32'h0000_001F, 16'h0002, 8'hAA);
        run(enc(0, `SCU_OP_DEC_REP), {12'h032, `SCU_CC_EQ}, 1'b0, 1'b0,
            arch_out, 1'b0);
        chk("suspended", 32'h0000_0000, {31'h0000_0000, suspended});
        chk_arch(32'h0000_000E, 32'h0000_001E, 16'h0001, 8'h4A);
        $display("test irq done");
    endtask : t_irq
    // Zero source, nonzero top nibble, zero destination, incrementing repeat
    task automatic t_bad;
        logic [15:0] w0 [4];
        logic [15:0] w1 [4];
        w0 = '{{`SCU_PFX_BW, 1'b0, 4'h0, `SCU_OP_DEC}, enc(0, `SCU_OP_DEC),
               enc(0, `SCU_OP_DEC), enc(1, 4'h6)};
        w1 = '{16'h0326, 16'h1326, 16'h0306, 16'h0326};
        for (int i = 0; i < 4; i++) begin
            run(w0[i], w1[i], 1'b0, 1'b0, '0, 1'b1);
        end
        $display("test bad done");
    endtask : t_bad
    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    // Main sequence after two reset cycles
    initial begin
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        #1;
        chk("idle", 32'h0000_0000, {27'h000_0000, mem_out.req, busy, done, bad_op, suspended});
        chk_arch(32'h0000_0000, 32'h0000_0000, 16'h0000, 8'h00);
        t_single_dec();
        t_cc_all();
        t_bad();
        t_repeat();
        t_irq();
        end_of_test();
    end
    // Watchdog: the tests need well under 2000 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        $display("[ERR] watchdog expected finish seen hang");
        end_of_test();
    end
endmodule : test_string_compare_unit
`default_nettype wire
